// ===== common/fd_pkg.sv
package fd_pkg;

   // ------------------------------------------------------------
   // register addresses and values after reset
   // ------------------------------------------------------------
   localparam logic [7:0] FD_ADDR_CTRL = 8'h27;
   localparam logic [7:0] FD_ADDR_SUPPLY = 8'h28;
   localparam logic [7:0] FD_ADDR_FRAC_HI = 8'h29;
   localparam logic [7:0] FD_ADDR_FRAC_LO = 8'h2a;
   localparam logic [15:0] FD_RST_CTRL = 16'h0679;
   localparam logic [15:0] FD_RST_SUPPLY = 16'h0008;
   localparam logic [15:0] FD_RST_FRAC_HI = 16'h8000;
   localparam logic [15:0] FD_RST_FRAC_LO = 16'h0000;

   // ------------------------------------------------------------
   // field positions of the divider and spread control register
   // ------------------------------------------------------------
   localparam int FD_POS_DLY = 15;
   localparam int FD_POS_BYP = 14;
   localparam int FD_POS_FRST = 13;
   localparam int FD_POS_SRC = 12;
   localparam int FD_POS_CNT_HI = 11;
   localparam int FD_POS_CNT_LO = 9;
   localparam int FD_POS_TYPE = 8;
   localparam int FD_POS_SPR_HI = 7;
   localparam int FD_POS_SPR_LO = 6;
   localparam int FD_POS_FMOD_HI = 5;
   localparam int FD_POS_FMOD_LO = 4;
   localparam int FD_POS_SSC_EN = 3;
   localparam int FD_POS_SMOOTH = 0;
   localparam int FD_POS_LO_HI = 8;
   localparam logic [15:0] FD_LO_USED_MASK = 16'h01ff;

   // ------------------------------------------------------------
   // fraction width and spread tables
   // ------------------------------------------------------------
   localparam int FD_FRAC_W = 25;
   localparam logic [9:0] FD_FMOD_C0 = 10'h0f0; // 240
   localparam logic [9:0] FD_FMOD_C1 = 10'h190; // 400
   localparam logic [9:0] FD_FMOD_C2 = 10'h208; // 520
   localparam logic [9:0] FD_FMOD_C3 = 10'h22c; // 556
   // spread depth in tenths of a percent, for down and centre spread
   localparam logic [5:0] FD_DEPTH_C0 = 6'h05;
   localparam logic [5:0] FD_DEPTH_C1 = 6'h0a;
   localparam logic [5:0] FD_DEPTH_C2 = 6'h14;
   localparam logic [5:0] FD_DEPTH_C3 = 6'h32;
   localparam logic [9:0] FD_DEPTH_SCALE = 10'h3e8; // 1000

   typedef enum logic {FD_SSC_CENTER, FD_SSC_DOWN} fd_ssc_type_t;
   typedef enum logic {FD_DLY_IDLE, FD_DLY_WAIT} fd_dly_state_t;

   function automatic logic [9:0] fd_fmod_cycles(input logic [1:0] code);
      case (code)
         2'h0: fd_fmod_cycles = FD_FMOD_C0;
         2'h1: fd_fmod_cycles = FD_FMOD_C1;
         2'h2: fd_fmod_cycles = FD_FMOD_C2;
         default: fd_fmod_cycles = FD_FMOD_C3;
      endcase
   endfunction

   function automatic logic [5:0] fd_depth_tenths(input logic [1:0] code);
      case (code)
         2'h0: fd_depth_tenths = FD_DEPTH_C0;
         2'h1: fd_depth_tenths = FD_DEPTH_C1;
         2'h2: fd_depth_tenths = FD_DEPTH_C2;
         default: fd_depth_tenths = FD_DEPTH_C3;
      endcase
   endfunction

endpackage

// ===== common/fd_ssc_if.sv
`timescale 1ns/1ps
interface fd_ssc_if;
   import fd_pkg::*;
   logic tick;
   logic enable;
   logic clear;
   logic [2:0] div_value;
   fd_ssc_type_t ptype;
   logic [1:0] depth;
   logic [1:0] fmod;
   logic [FD_FRAC_W-1:0] base;
   logic [FD_FRAC_W-1:0] eff;
   modport ctl (output tick, enable, clear, div_value, ptype, depth, fmod,
      base, input eff);
   modport gen (input tick, enable, clear, div_value, ptype, depth, fmod,
      base, output eff);
endinterface

// ===== core/fd_phase_acc.sv
`timescale 1ns/1ps
module fd_phase_acc
   import fd_pkg::*;
#(
   parameter int W = FD_FRAC_W
) (
   // clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // control
   input wire logic clear,
   input wire logic in_tick,
   input wire logic [W-1:0] step,
   // output pulse
   output logic out_tick
);
   logic [W-1:0] acc_reg;
   logic [W:0] sum;

   // carry out of the phase sum marks one output edge
   assign sum = {1'b0, acc_reg} + {1'b0, step};

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         acc_reg <= '0;
         out_tick <= 1'b0;
      end else if (clear) begin
         acc_reg <= '0;
         out_tick <= 1'b0;
      end else begin
         out_tick <= in_tick & sum[W];
         if (in_tick) begin
            acc_reg <= sum[W-1:0];
         end
      end
   end
endmodule

// ===== core/fd_ssc_gen.sv
`timescale 1ns/1ps
module fd_ssc_gen
   import fd_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // spread settings and result
   fd_ssc_if.gen ssc
);
   logic [2:0] pre_reg;
   logic [9:0] ph_reg;
   logic [2:0] div_m1;
   logic step;
   logic [9:0] cycles;
   logic [9:0] half;
   logic [9:0] tri_pos;
   logic [30:0] peak_prod;
   logic [FD_FRAC_W-1:0] peak;
   logic [34:0] mag_prod;
   logic [FD_FRAC_W-1:0] mag;
   logic [FD_FRAC_W:0] center_sum;
   logic [FD_FRAC_W-1:0] eff_next;

   // counter clock divided by the programmed value, zero acts as one
   assign div_m1 = (ssc.div_value == 3'h0) ? 3'h0 : ssc.div_value - 3'h1;
   assign step = ssc.tick & (pre_reg >= div_m1);

   // triangle over one modulation period
   assign cycles = fd_fmod_cycles(ssc.fmod);
   assign half = {1'b0, cycles[9:1]};
   assign tri_pos = (ph_reg < half) ? ph_reg : cycles - ph_reg;

   // peak deviation and present deviation of the frequency word
   assign peak_prod = {6'h00, ssc.base} * {25'h0, fd_depth_tenths(ssc.depth)};
   assign peak = FD_FRAC_W'(peak_prod / {21'h0, FD_DEPTH_SCALE});
   assign mag_prod = {10'h000, peak} * {25'h0, tri_pos};
   assign mag = FD_FRAC_W'(mag_prod / {25'h0, half});
   assign center_sum = {1'b0, ssc.base} + {2'b00, peak[FD_FRAC_W-1:1]};

   // down spread only lowers, centre spread swings both ways
   always_comb begin
      eff_next = ssc.base;
      if (ssc.enable) begin
         if (ssc.ptype == FD_SSC_DOWN) begin
            eff_next = ssc.base - mag;
         end else begin
            eff_next = center_sum[FD_FRAC_W-1:0] - mag;
         end
      end
   end

   // prescaler and modulation phase
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         pre_reg <= 3'h0;
         ph_reg <= 10'h000;
      end else if (ssc.clear || !ssc.enable) begin
         pre_reg <= 3'h0;
         ph_reg <= 10'h000;
      end else if (ssc.tick) begin
         pre_reg <= step ? 3'h0 : pre_reg + 3'h1;
         if (step) begin
            ph_reg <= (ph_reg >= cycles - 10'h001) ? 10'h000 :
                      ph_reg + 10'h001;
         end
      end
   end

   // registered effective word
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         ssc.eff <= {FD_RST_FRAC_HI, FD_RST_FRAC_LO[8:0]};
      end else begin
         ssc.eff <= eff_next;
      end
   end
endmodule

// ===== core/fd_divider_top.sv
// Functional notes
// - mode bit 15 selects synthesis (0) or programmable delay (1).
// - bypass bit 14 set routes input straight out, skipping all registers.
// - bit 12 clocks spread counter from divider output (0) or reference (1).
// - bits 11-9 divide the spread counter clock; reset value 3.
// - bits 7-6 pick spread depth, down or centre per type; reset 1.
// - bits 5-4 pick modulation period 240/400/520/556; reset 3.
// - bit 0 set applies divider changes glitch-free, clear applies at once.
// - upper 16 fraction bits reset to 0x8000, also the delay amount.
// - lower 9 fraction bits in bits 8-0, reset 0; bits 15-9 reserved.
`timescale 1ns/1ps
module fd_divider_top
   import fd_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   output logic reg_rvalid,
   // clock enables in
   input wire logic fod_in_tick,
   input wire logic ref_tick,
   // divider output and status
   output logic div_out_tick,
   output logic [FD_FRAC_W-1:0] active_fraction,
   output logic delay_busy
);

   // ------------------------------------------------------------
   // register storage
   // ------------------------------------------------------------
   logic [15:0] ctrl_reg;
   logic [15:0] supply_reg;
   logic [15:0] frac_hi_reg;
   logic [15:0] frac_lo_reg;

   // address decode
   logic hit_ctrl;
   logic hit_supply;
   logic hit_hi;
   logic hit_lo;
   assign hit_ctrl = (reg_addr == FD_ADDR_CTRL);
   assign hit_supply = (reg_addr == FD_ADDR_SUPPLY);
   assign hit_hi = (reg_addr == FD_ADDR_FRAC_HI);
   assign hit_lo = (reg_addr == FD_ADDR_FRAC_LO);

   // writes, unmapped addresses ignored
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         ctrl_reg <= FD_RST_CTRL;
         supply_reg <= FD_RST_SUPPLY;
         frac_hi_reg <= FD_RST_FRAC_HI;
         frac_lo_reg <= FD_RST_FRAC_LO;
      end else if (reg_wr) begin
         if (hit_ctrl) begin
            ctrl_reg <= reg_wdata;
         end
         if (hit_supply) begin
            supply_reg <= reg_wdata;
         end
         if (hit_hi) begin
            frac_hi_reg <= reg_wdata;
         end
         if (hit_lo) begin
            frac_lo_reg <= reg_wdata;
         end
      end
   end

   // read mux, unmapped reads return zero
   logic [15:0] rd_mux;
   assign rd_mux = hit_ctrl ? ctrl_reg :
                   hit_supply ? supply_reg :
                   hit_hi ? frac_hi_reg :
                   hit_lo ? frac_lo_reg : 16'h0000;

   // registered read data, one cycle after the strobe
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         reg_rdata <= 16'h0000;
         reg_rvalid <= 1'b0;
      end else begin
         reg_rvalid <= reg_rd;
         if (reg_rd) begin
            reg_rdata <= rd_mux;
         end
      end
   end

   // ------------------------------------------------------------
   // field extraction
   // ------------------------------------------------------------
   logic delay_mode;
   logic bypass;
   logic fod_reset;
   logic ssc_src_ref;
   logic [2:0] ssc_div;
   fd_ssc_type_t ssc_type;
   logic [1:0] ssc_depth;
   logic [1:0] ssc_fmod;
   logic ssc_on;
   logic smooth;
   logic [FD_FRAC_W-1:0] prog_fraction;
   assign delay_mode = ctrl_reg[FD_POS_DLY];
   assign bypass = ctrl_reg[FD_POS_BYP];
   assign fod_reset = ctrl_reg[FD_POS_FRST];
   assign ssc_src_ref = ctrl_reg[FD_POS_SRC];
   assign ssc_div = ctrl_reg[FD_POS_CNT_HI:FD_POS_CNT_LO];
   assign ssc_type = fd_ssc_type_t'(ctrl_reg[FD_POS_TYPE]);
   assign ssc_depth = ctrl_reg[FD_POS_SPR_HI:FD_POS_SPR_LO];
   assign ssc_fmod = ctrl_reg[FD_POS_FMOD_HI:FD_POS_FMOD_LO];
   assign ssc_on = ctrl_reg[FD_POS_SSC_EN];
   assign smooth = ctrl_reg[FD_POS_SMOOTH];
   // reserved upper bits of the lower word take no part
   assign prog_fraction = {frac_hi_reg, frac_lo_reg[FD_POS_LO_HI:0]};

   // ------------------------------------------------------------
   // applied fraction word
   // ------------------------------------------------------------
   logic [FD_FRAC_W-1:0] frac_apply_reg;
   logic acc_tick;
   logic load_now;
   // glitch-free loads wait for an output edge; divider reset or delay mode loads at once
   assign load_now = !smooth || fod_reset || acc_tick || delay_mode;

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         frac_apply_reg <= {FD_RST_FRAC_HI, FD_RST_FRAC_LO[8:0]};
      end else if (load_now) begin
         frac_apply_reg <= prog_fraction;
      end
   end

   // ------------------------------------------------------------
   // spread modulation
   // ------------------------------------------------------------
   fd_ssc_if ssc ();
   assign ssc.tick = ssc_src_ref ? ref_tick : div_out_tick;
   assign ssc.enable = ssc_on & ~delay_mode & ~bypass;
   assign ssc.clear = fod_reset;
   assign ssc.div_value = ssc_div;
   assign ssc.ptype = ssc_type;
   assign ssc.depth = ssc_depth;
   assign ssc.fmod = ssc_fmod;
   assign ssc.base = frac_apply_reg;

   fd_ssc_gen u_ssc (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .ssc(ssc.gen)
   );

   // ------------------------------------------------------------
   // synthesis path
   // ------------------------------------------------------------
   logic synth_in;
   assign synth_in = fod_in_tick & ~delay_mode & ~bypass;

   fd_phase_acc #(
      .W(FD_FRAC_W)
   ) u_acc (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .clear(fod_reset),
      .in_tick(synth_in),
      .step(ssc.eff),
      .out_tick(acc_tick)
   );

   // ------------------------------------------------------------
   // delay path
   // ------------------------------------------------------------
   fd_dly_state_t dly_state_reg;
   fd_dly_state_t dly_state_next;
   logic [15:0] dly_cnt_reg;
   logic [15:0] dly_cnt_next;
   logic dly_pulse_reg;
   logic dly_pulse_next;

   // an input edge taken while idle reappears upper-word plus one cycles later; edges while busy are dropped
   always_comb begin
      dly_state_next = dly_state_reg;
      dly_cnt_next = dly_cnt_reg;
      dly_pulse_next = 1'b0;
      case (dly_state_reg)
         FD_DLY_IDLE: begin
            if (delay_mode && !bypass && fod_in_tick) begin
               if (frac_hi_reg == 16'h0000) begin
                  dly_pulse_next = 1'b1;
               end else begin
                  dly_cnt_next = frac_hi_reg - 16'h0001;
                  dly_state_next = FD_DLY_WAIT;
               end
            end
         end
         FD_DLY_WAIT: begin
            if (dly_cnt_reg == 16'h0000) begin
               dly_pulse_next = 1'b1;
               dly_state_next = FD_DLY_IDLE;
            end else begin
               dly_cnt_next = dly_cnt_reg - 16'h0001;
            end
         end
         default: begin
            dly_state_next = FD_DLY_IDLE;
         end
      endcase
      if (!delay_mode || fod_reset) begin
         dly_state_next = FD_DLY_IDLE;
         dly_pulse_next = 1'b0;
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         dly_state_reg <= FD_DLY_IDLE;
         dly_cnt_reg <= 16'h0000;
         dly_pulse_reg <= 1'b0;
      end else begin
         dly_state_reg <= dly_state_next;
         dly_cnt_reg <= dly_cnt_next;
         dly_pulse_reg <= dly_pulse_next;
      end
   end

   // ------------------------------------------------------------
   // output selection
   // ------------------------------------------------------------
   logic reg_path_out;
   assign reg_path_out = fod_reset ? 1'b0 :
                         delay_mode ? dly_pulse_reg : acc_tick;
   // bypass passes the input edge with no register in the path
   assign div_out_tick = bypass ? fod_in_tick : reg_path_out;
   assign active_fraction = ssc.eff;
   assign delay_busy = (dly_state_reg == FD_DLY_WAIT);

endmodule

// ===== sim/fd_divider_monitor.sv
`timescale 1ns/1ps
module fd_divider_checker
   import fd_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_rdata,
   input wire logic reg_rvalid,
   // divider side
   input wire logic fod_in_tick,
   input wire logic ref_tick,
   input wire logic div_out_tick,
   input wire logic [FD_FRAC_W-1:0] active_fraction,
   input wire logic delay_busy
);
   // ----
   // shadow registers
   // ----
   logic [15:0] c_reg;
   logic [15:0] s_reg;
   logic [15:0] h_reg;
   logic [15:0] l_reg;
   logic [3:0] q_reg;
   logic [15:0] rd_exp;
   logic wr_c;
   logic norm;
   logic dly;
   // quiet count: cycles since the last control write
   assign wr_c = reg_wr && reg_addr == FD_ADDR_CTRL;
   assign norm = !c_reg[15] && !c_reg[14] && !c_reg[13] && q_reg > 4'h3;
   assign dly = c_reg[15] && !c_reg[14] && !c_reg[13] && q_reg > 4'h1;
   assign rd_exp = reg_addr == FD_ADDR_CTRL ? c_reg :
      reg_addr == FD_ADDR_SUPPLY ? s_reg :
      reg_addr == FD_ADDR_FRAC_HI ? h_reg :
      reg_addr == FD_ADDR_FRAC_LO ? l_reg : 16'h0000;
   // mirror of every write
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         c_reg <= 16'h0679;
         s_reg <= 16'h0008;
         h_reg <= 16'h8000;
         l_reg <= 16'h0000;
         q_reg <= 4'h0;
      end else begin
         if (wr_c) c_reg <= reg_wdata;
         if (reg_wr && reg_addr == FD_ADDR_SUPPLY) s_reg <= reg_wdata;
         if (reg_wr && reg_addr == FD_ADDR_FRAC_HI) h_reg <= reg_wdata;
         if (reg_wr && reg_addr == FD_ADDR_FRAC_LO) l_reg <= reg_wdata;
         q_reg <= wr_c ? 4'h0 : q_reg + {3'h0, ~&q_reg};
      end
   end
   // ----
   // properties
   // ----
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (sys_rst);
   property p_rd_back;
      reg_rd |=> reg_rvalid && reg_rdata == $past(rd_exp);
   endproperty
   a_rd_back: assert property (p_rd_back)
      else $error("read data or valid wrong");
   property p_bypass;
      c_reg[14] && q_reg > 4'h1 |-> div_out_tick == fod_in_tick;
   endproperty
   a_bypass: assert property (p_bypass)
      else $error("bypass output differs from input");
   property p_syn_src;
      !c_reg[15] && !c_reg[14] && q_reg > 4'h1 && div_out_tick
         |-> $past(fod_in_tick);
   endproperty
   a_syn_src: assert property (p_syn_src)
      else $error("output pulse without input tick");
   property p_dly0;
      dly && h_reg == 16'h0000 && fod_in_tick && !delay_busy
         |=> div_out_tick;
   endproperty
   a_dly0: assert property (p_dly0)
      else $error("zero delay pulse late");
   property p_dly1;
      dly && h_reg == 16'h0001 && fod_in_tick && !delay_busy
         |=> !div_out_tick ##1 div_out_tick;
   endproperty
   a_dly1: assert property (p_dly1)
      else $error("one cycle delay wrong");
   property p_busy;
      $rose(delay_busy) |-> c_reg[15];
   endproperty
   a_busy: assert property (p_busy)
      else $error("busy outside delay mode");
   property p_imm;
      reg_wr && reg_addr == FD_ADDR_FRAC_HI && norm && !c_reg[0]
         && !c_reg[3] |-> ##3 active_fraction
         == $past({h_reg, l_reg[8:0]}, 2);
   endproperty
   a_imm: assert property (p_imm)
      else $error("immediate word not applied");
   property p_smooth;
      norm && c_reg[0] && !c_reg[3] && $changed(active_fraction)
         |-> div_out_tick || $past(div_out_tick)
         || $past(div_out_tick, 2);
   endproperty
   a_smooth: assert property (p_smooth)
      else $error("word changed away from a pulse");
   property p_ref;
      norm && c_reg[3] && c_reg[12] && $changed(active_fraction)
         && {h_reg, l_reg[8:0]} == $past({h_reg, l_reg[8:0]}, 3)
         |-> $past(ref_tick) || $past(ref_tick, 2) || $past(ref_tick, 3)
         || $past(ref_tick, 4);
   endproperty
   a_ref: assert property (p_ref)
      else $error("spread step without reference tick");
   c_rd: cover property (reg_rvalid);
   c_dly: cover property (delay_busy ##1 div_out_tick);
   c_spr: cover property (c_reg[3] && $changed(active_fraction));
endmodule

bind fd_divider_top fd_divider_checker i_chk (
   .mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
   .fod_in_tick(fod_in_tick), .ref_tick(ref_tick),
   .div_out_tick(div_out_tick), .active_fraction(active_fraction),
   .delay_busy(delay_busy)
);

// ===== sim/tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, e, s) \
   begin \
      n_tests++; \
      if ((s) !== (e)) begin \
         n_fail++; \
         $display("mismatch %s exp %h got %h", nm, e, s); \
      end \
   end
module tb_top
   import fd_pkg::*;
;
   // ----
   // design hookup
   // ----
   logic mclk = 1'b0;
   logic sys_rst = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic [15:0] reg_wdata = 16'h0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic fod_in_tick = 1'b0;
   logic ref_tick = 1'b0;
   logic [15:0] reg_rdata;
   logic reg_rvalid;
   logic div_out_tick;
   logic [FD_FRAC_W-1:0] active_fraction;
   logic delay_busy;
   int n_fail = 0;
   int n_tests = 0;
   int sp [4] = '{240, 400, 520, 556};
   logic [7:0] ad [5] = '{8'h27, 8'h28, 8'h29, 8'h2a, 8'h30};
   logic [15:0] mem [5] = '{16'h0679, 16'h0008, 16'h8000, 16'h0, 16'h0};
   always #12.5 mclk = ~mclk;
   fd_divider_top i_dut (.mclk(mclk), .sys_rst(sys_rst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
      .fod_in_tick(fod_in_tick), .ref_tick(ref_tick),
      .div_out_tick(div_out_tick), .active_fraction(active_fraction),
      .delay_busy(delay_busy));
   // ----
   // bus tasks and expectations
   // ----
   task automatic idle(input int n);
      repeat (n) @(negedge mclk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(negedge mclk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge mclk);
      reg_wr = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      @(negedge mclk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge mclk);
      reg_rd = 1'b0;
      d = reg_rdata;
   endtask
   task automatic wrap_up();
      $display("tests %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   function automatic int pulses(logic [24:0] f, int t);
      return int'((longint'(t) * f) >> 25);
   endfunction
   // spread limits: top or bottom of the triangle
   function automatic logic [24:0] lim(logic [24:0] b, int c, bit dn,
      bit lo);
      int tn [4] = '{5, 10, 20, 50};
      longint pk;
      longint r;
      pk = longint'(b) * tn[c] / 1000;
      r = dn ? longint'(b) : longint'(b) + pk / 2;
      return lo ? 25'(r - pk) : 25'(r);
   endfunction
   // ----
   // scenarios
   // ----
   initial begin
      logic [15:0] d;
      logic [24:0] f;
      logic [24:0] g;
      logic [24:0] hs;
      logic [24:0] ls;
      logic [24:0] mn;
      int cnt;
      int first;
      int k;
      int n;
      int t1;
      int t2;
      int per;
      void'($urandom(40));
      idle(2);
      sys_rst = 1'b0;
      // reset values, random writes, unmapped place
      for (k = 0; k < 13; k++) begin
         n = (k < 5) ? k : int'($urandom % 5);
         d = 16'($urandom) & (n == 0 ? 16'hfff9 : n == 1 ? 16'h0008 :
            n == 3 ? 16'h01ff : 16'hffff);
         if (k >= 5) wr(ad[n], d);
         if (k >= 5 && n < 4) mem[n] = d;
         rd(ad[n], d);
         `CHK("readback", mem[n], d)
         `CHK("rvalid", 1'b1, reg_rvalid)
      end
      // synthesis: pulse count over a tick burst
      for (k = 0; k < 4; k++) begin
         f = (k == 0) ? 25'h1000000 : 25'($urandom) | 25'h0800000;
         wr(FD_ADDR_CTRL, 16'h2000);
         wr(FD_ADDR_CTRL, 16'h0000);
         idle(4);
         wr(FD_ADDR_FRAC_HI, f[24:9]);
         wr(FD_ADDR_FRAC_LO, {7'h00, f[8:0]});
         idle(3);
         `CHK("fraction", f, active_fraction)
         cnt = 0;
         for (n = 0; n < 67; n++) begin
            fod_in_tick = n < 64;
            @(negedge mclk);
            cnt += int'(div_out_tick);
         end
         `CHK("pulses", pulses(f, 64), cnt)
      end
      // smooth switch holds the old word until a pulse
      wr(FD_ADDR_CTRL, 16'h0001);
      idle(4);
      g = {f[24:9] ^ 16'h4000, f[8:0]};
      wr(FD_ADDR_FRAC_HI, g[24:9]);
      idle(4);
      `CHK("held word", f, active_fraction)
      fod_in_tick = 1'b1;
      for (n = 0; n < 200 && !div_out_tick; n++) @(negedge mclk);
      fod_in_tick = 1'b0;
      if (n >= 200) begin
         n_fail++;
         wrap_up();
      end
      idle(3);
      `CHK("new word", g, active_fraction)
      // delay mode: one pulse n+1 cycles on, busy ticks ignored
      wr(FD_ADDR_CTRL, 16'h8000);
      for (k = 0; k < 4; k++) begin
         n = (k < 2) ? k : 2 + int'($urandom % 30);
         wr(FD_ADDR_FRAC_HI, 16'(n));
         idle(4);
         cnt = 0;
         first = -1;
         for (t1 = 0; t1 < n + 6; t1++) begin
            fod_in_tick = t1 == 0 || (t1 == 1 && n > 1);
            @(negedge mclk);
            if (t1 == 0) t2 = int'(delay_busy);
            if (div_out_tick && first < 0) first = t1;
            cnt += int'(div_out_tick);
         end
         `CHK("delay", n, first)
         `CHK("delay busy", int'(n > 0), t2)
         `CHK("delay pulses", 1, cnt)
      end
      // bypass: output follows input in the same cycle
      wr(FD_ADDR_CTRL, 16'h4000);
      for (k = 0; k < 16; k++) begin
         fod_in_tick = 1'($urandom);
         #2;
         `CHK("bypass", fod_in_tick, div_out_tick)
         @(negedge mclk);
      end
      fod_in_tick = 1'b0;
      // spread from the reference: depth limits and period per code
      f = 25'h1400000 ^ 25'($urandom % 65536);
      wr(FD_ADDR_CTRL, 16'h0000);
      wr(FD_ADDR_FRAC_HI, f[24:9]);
      wr(FD_ADDR_FRAC_LO, {7'h00, f[8:0]});
      ref_tick = 1'b1;
      for (k = 0; k < 4; k++) begin
         per = sp[k] * (k == 0 ? 1 : k);
         mn = lim(f, k, k[0], 1'b1);
         wr(FD_ADDR_CTRL, 16'h0000);
         wr(FD_ADDR_CTRL, {4'h1, 3'(k), 1'(k), 2'(k), 2'(k), 4'h8});
         hs = 25'h0;
         ls = 25'h1ffffff;
         t1 = -1;
         t2 = -1;
         for (n = 0; n < 2 * per + 20; n++) begin
            g = active_fraction;
            @(negedge mclk);
            if (active_fraction > hs) hs = active_fraction;
            if (active_fraction < ls) ls = active_fraction;
            if (active_fraction == mn && g != mn) begin
               t1 = t2;
               t2 = n;
            end
         end
         `CHK("spread top", lim(f, k, k[0], 1'b0), hs)
         `CHK("spread low", mn, ls)
         `CHK("period", per, t2 - t1)
      end
      // divider clock as counter source: reference ticks must not step
      wr(FD_ADDR_CTRL, 16'h0008);
      idle(3);
      g = active_fraction;
      idle(20);
      `CHK("divider source", g, active_fraction)
      ref_tick = 1'b0;
      wrap_up();
   end
endmodule
